// *** core/cfd_pkg.sv ***
// Package: constants, types and register map for configuration decode
//
// Functional notes
// - Write protect field gates program memory writes
// - Two-speed start runs fast RC first
// - Initial oscillator code picks start-up clock
// - Switch mode field gates switching and monitor
// - Oscillator pin: clock out or GPIO
// - Primary oscillator mode decode, four modes
// - Fixed watchdog enable overrides software bit
// - Window field selects non-window or window
// - PLL switch waits for lock if enabled
// - Prescaler ratio 128 or 32
// - Postscaler power-of-two ratio from code
// - PWM pins tri-stated or driven at reset
// - High-side PWM polarity from field
// - Low-side PWM polarity from field
// - Power-up timer 2 ms doubling, 000 off
// - Debug channel pair select, 00 reserved
// - Hold execution twenty microseconds after power-on
// - Reapply hold-off after every power-down
// - Brown-out reset reselects clock from fields
// - PLL source holds clock until lock
package cfd_pkg;

  localparam logic [11:0] ADDR_GS   = 12'h000;
  localparam logic [11:0] ADDR_OSEL = 12'h004;
  localparam logic [11:0] ADDR_OCFG = 12'h008;
  localparam logic [11:0] ADDR_WDT  = 12'h00C;
  localparam logic [11:0] ADDR_POR  = 12'h010;
  localparam logic [11:0] ADDR_ICD  = 12'h014;
  localparam logic [11:0] ADDR_STAT = 12'h018;
  localparam logic [11:0] ADDR_CTRL = 12'h01C;

  // Field positions
  localparam int WRITE_PROT_BIT  = 0;
  localparam int OSC_SRC_LSB     = 0;
  localparam int TWO_SPEED_BIT   = 7;
  localparam int PRI_MODE_LSB    = 0;
  localparam int OSCIO_BIT       = 2;
  localparam int SWITCH_MODE_LSB = 6;
  localparam int POST_LSB        = 0;
  localparam int PRE_BIT         = 4;
  localparam int PLLK_BIT        = 5;
  localparam int WIN_BIT         = 6;
  localparam int WDT_FIXED_BIT   = 7;
  localparam int PWRUP_LSB       = 0;
  localparam int HIGH_POL_BIT    = 4;
  localparam int LOW_POL_BIT     = 5;
  localparam int PWM_PIN_BIT     = 6;
  localparam int DBG_CH_LSB      = 0;

  // Control register bits
  localparam int CTRL_SWDT_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;

  // Status register bits
  localparam int ST_RUN_BIT  = 0;
  localparam int ST_CLK_BIT  = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_WDT_BIT  = 3;

  localparam logic [31:0] CLK_HZ         = 32'd250_000_000;
  localparam int          T_STARTUP_US   = 20;
  localparam int          STARTUP_CYC    = (T_STARTUP_US * 250 + 0) ;
  localparam int          PWRUP_BASE_MS  = 2;
  localparam int          PWRUP_BASE_CYC = PWRUP_BASE_MS * 250_000;
  localparam logic [7:0]  CFG_RESET      = 8'hFF;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

  typedef enum logic [2:0] {
    OSC_FAST_RC_DIV  = 3'b111,
    OSC_FAST_RC_16   = 3'b110,
    OSC_LOW_POWER_RC = 3'b101,
    OSC_SEC          = 3'b100,
    OSC_PRI_PLL      = 3'b011,
    OSC_PRI          = 3'b010,
    OSC_FAST_RC_PLL  = 3'b001,
    OSC_FAST_RC      = 3'b000
  } cfd_osc_e;

  typedef enum logic [1:0] {
    PM_OFF        = 2'b11,
    PM_HIGH_SPEED = 2'b10,
    PM_STD_XTAL   = 2'b01,
    PM_EXT_CLK    = 2'b00
  } cfd_pmode_e;

  typedef enum logic [3:0] {
    ST_STARTUP = 4'b0001,
    ST_PWRUP   = 4'b0010,
    ST_LOCK    = 4'b0100,
    ST_RUN     = 4'b1000
  } cfd_state_e;

  typedef struct packed {
    logic       flash_write_en;
    cfd_osc_e   clk_source;
    logic       two_speed;
    logic       clk_switch_en;
    logic       fail_safe_en;
    cfd_pmode_e pri_mode;
    logic       osc_pin_clkout;
    logic       osc_pin_gpio;
    logic       pll_lock_wait;
  } cfd_clk_s;

  typedef struct packed {
    logic        wdt_run;
    logic        low_power_internal_rc_on;
    logic        window_mode;
    logic [7:0]  pre_ratio_log2;
    logic [4:0]  post_ratio_log2;
  } cfd_wdt_s;

  typedef struct packed {
    logic       pins_tristate;
    logic       high_active_high;
    logic       low_active_high;
    logic [1:0] debug_pair;
    logic       debug_reserved;
  } cfd_pwm_s;

endpackage

// *** core/cfd_decode.sv ***
// Configuration word latch, decode, start-up sequencer and APB view
//
// Local design decisions: the register offsets and the APB interface to the registers.
module cfd_decode
  import cfd_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int PWRUP_UNIT_CYC = PWRUP_BASE_CYC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  nv_general_segment,
  input  wire logic [7:0]  nv_osc_select,
  input  wire logic [7:0]  nv_osc_config,
  input  wire logic [7:0]  nv_watchdog,
  input  wire logic [7:0]  nv_power_on,
  input  wire logic [7:0]  nv_debug,
  input  wire logic        brownout_reset,
  input  wire logic        power_down,
  input  wire logic        pll_locked,
  input  wire logic        selected_osc_ready,
  output cfd_clk_s         clk_cfg,
  output cfd_wdt_s         wdt_cfg,
  output cfd_pwm_s         pwm_cfg,
  output logic             code_run,
  output logic             sys_clk_hold,
  output logic             on_selected_src
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration latch
  logic [7:0] gs_q, osel_q, ocfg_q, wdt_q, por_q, icd_q;
  logic [7:0] gs_d, osel_d, ocfg_d, wdt_d, por_d, icd_d;
  logic       load_q, load_d;

  // Words reload only at reset release or brown-out, never while running
  always_comb
  begin
    load_d = 1'b0;
    gs_d   = gs_q;
    osel_d = osel_q;
    ocfg_d = ocfg_q;
    wdt_d  = wdt_q;
    por_d  = por_q;
    icd_d  = icd_q;
    if (load_q || brownout_reset)
    begin
      gs_d   = nv_general_segment;
      osel_d = nv_osc_select;
      ocfg_d = nv_osc_config;
      wdt_d  = nv_watchdog;
      por_d  = nv_power_on;
      icd_d  = nv_debug;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      load_q <= 1'b1;
      gs_q   <= CFG_RESET;
      osel_q <= CFG_RESET;
      ocfg_q <= CFG_RESET;
      wdt_q  <= CFG_RESET;
      por_q  <= CFG_RESET;
      icd_q  <= CFG_RESET;
    end
    else
    begin
      load_q <= load_d;
      gs_q   <= gs_d;
      osel_q <= osel_d;
      ocfg_q <= ocfg_d;
      wdt_q  <= wdt_d;
      por_q  <= por_d;
      icd_q  <= icd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: regulator start-up, power-up timer, PLL lock
  cfd_state_e  st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic        swdt_q, swdt_d;
  logic [31:0] pwrup_cycles;
  logic        uses_pll;
  logic        resume_q, resume_d;
  logic        wake_req;

  assign uses_pll = (osel_q[OSC_SRC_LSB +: 3] == OSC_PRI_PLL) ||
                    (osel_q[OSC_SRC_LSB +: 3] == OSC_FAST_RC_PLL);

  // Software wake strobe replays the hold-off
  assign wake_req = psel && penable && pwrite && (paddr == ADDR_CTRL) && pwdata[CTRL_WAKE_BIT];

  // Code 000 gives zero length: timer skipped
  always_comb
  begin
    pwrup_cycles = 32'd0;
    if (por_q[PWRUP_LSB +: 3] != 3'b000)
      pwrup_cycles = 32'(PWRUP_UNIT_CYC) << (por_q[PWRUP_LSB +: 3] - 3'd1);
  end

  always_comb
  begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    if (power_down || brownout_reset || resume_q)
    begin
      st_d  = ST_STARTUP;
      cnt_d = 32'd0;
    end
    else
    begin
      unique case (st_q)
        ST_STARTUP:
        begin
          if (cnt_q >= 32'(STARTUP_CYCLES - 1))
          begin
            st_d  = ST_PWRUP;
            cnt_d = 32'd0;
          end
          else
            cnt_d = cnt_q + 32'd1;
        end
        ST_PWRUP:
        begin
          if (cnt_q >= pwrup_cycles)
          begin
            st_d  = ST_LOCK;
            cnt_d = 32'd0;
          end
          else
            cnt_d = cnt_q + 32'd1;
        end
        ST_LOCK:
        begin
          if (!uses_pll || pll_locked)
            st_d = ST_RUN;
        end
        ST_RUN:
        begin
          st_d = ST_RUN;
        end
      endcase
    end
  end

  always_comb
  begin
    swdt_d   = swdt_q;
    resume_d = wake_req;
    if (psel && penable && pwrite && paddr == ADDR_CTRL)
    begin
      swdt_d = pwdata[CTRL_SWDT_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q     <= ST_STARTUP;
      cnt_q    <= 32'd0;
      swdt_q   <= 1'b0;
      resume_q <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      swdt_q   <= swdt_d;
      resume_q <= resume_d;
    end
  end

  assign code_run     = (st_q == ST_RUN);
  assign sys_clk_hold = (st_q == ST_LOCK) && uses_pll && !pll_locked;

  ////////////////////////////////////////////////////////////////////////////
  // Two-speed start: fast RC until selected source reports ready
  logic sel_q, sel_d;

  always_comb
  begin
    sel_d = sel_q;
    if (!osel_q[TWO_SPEED_BIT])
      sel_d = 1'b1;
    else if (selected_osc_ready && (!uses_pll || !wdt_q[PLLK_BIT] || pll_locked))
      sel_d = 1'b1;
    if (brownout_reset || power_down)
      sel_d = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_q <= 1'b0;
    else
      sel_q <= sel_d;
  end

  assign on_selected_src = sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings
  logic crystal_mode;
  assign crystal_mode = (ocfg_q[PRI_MODE_LSB +: 2] == PM_HIGH_SPEED) ||
                        (ocfg_q[PRI_MODE_LSB +: 2] == PM_STD_XTAL);

  always_comb
  begin
    clk_cfg.flash_write_en = gs_q[WRITE_PROT_BIT];
    clk_cfg.clk_source     = cfd_osc_e'(osel_q[OSC_SRC_LSB +: 3]);
    clk_cfg.two_speed      = osel_q[TWO_SPEED_BIT];
    clk_cfg.clk_switch_en  = !ocfg_q[SWITCH_MODE_LSB + 1];
    clk_cfg.fail_safe_en   = (ocfg_q[SWITCH_MODE_LSB +: 2] == 2'b00);
    clk_cfg.pri_mode       = cfd_pmode_e'(ocfg_q[PRI_MODE_LSB +: 2]);
    clk_cfg.osc_pin_clkout = !crystal_mode && ocfg_q[OSCIO_BIT];
    clk_cfg.osc_pin_gpio   = !crystal_mode && !ocfg_q[OSCIO_BIT];
    clk_cfg.pll_lock_wait  = wdt_q[PLLK_BIT];
    wdt_cfg.wdt_run         = wdt_q[WDT_FIXED_BIT] || swdt_q;
    wdt_cfg.low_power_internal_rc_on         = wdt_q[WDT_FIXED_BIT] || swdt_q;
    wdt_cfg.window_mode     = !wdt_q[WIN_BIT];
    wdt_cfg.pre_ratio_log2  = wdt_q[PRE_BIT] ? 8'd7 : 8'd5;
    wdt_cfg.post_ratio_log2 = {1'b0, wdt_q[POST_LSB +: 4]};
    pwm_cfg.pins_tristate    = por_q[PWM_PIN_BIT];
    pwm_cfg.high_active_high = por_q[HIGH_POL_BIT];
    pwm_cfg.low_active_high  = por_q[LOW_POL_BIT];
    pwm_cfg.debug_pair       = 2'd3 - icd_q[DBG_CH_LSB +: 2];
    pwm_cfg.debug_reserved   = (icd_q[DBG_CH_LSB +: 2] == 2'b00);
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, words read-only except control
  assign pready = 1'b1;

  always_comb
  begin
    pslverr = 1'b0;
    prdata  = RDATA_UNMAPPED;
    unique case (paddr)
      ADDR_GS:   prdata = {24'h0000_00, gs_q};
      ADDR_OSEL: prdata = {24'h0000_00, osel_q};
      ADDR_OCFG: prdata = {24'h0000_00, ocfg_q};
      ADDR_WDT:  prdata = {24'h0000_00, wdt_q};
      ADDR_POR:  prdata = {24'h0000_00, por_q};
      ADDR_ICD:  prdata = {24'h0000_00, icd_q};
      ADDR_STAT: prdata = {28'h000_0000, wdt_cfg.wdt_run, pll_locked, sel_q, code_run};
      ADDR_CTRL: prdata = {31'h0000_0000, swdt_q};
      default:   pslverr = psel && penable;
    endcase
  end

endmodule

// *** tb/cfd_decode_asserts.sv ***
// Concurrent checks on the configuration decoder ports
module cfd_decode_asserts
  import cfd_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        brownout_reset,
  input wire logic        power_down,
  input wire cfd_clk_s    clk_cfg,
  input wire cfd_wdt_s    wdt_cfg,
  input wire cfd_pwm_s    pwm_cfg,
  input wire logic        code_run,
  input wire logic        sys_clk_hold
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog bits excluded: the soft enable may move them
  property p_hold;
    $past(presetn, 2) && !brownout_reset && !$past(brownout_reset)
      && !$past(brownout_reset, 2) |-> $stable({clk_cfg, pwm_cfg});
  endproperty
  property p_fsm;
    clk_cfg.fail_safe_en |-> clk_cfg.clk_switch_en;
  endproperty
  property p_pin;
    !(clk_cfg.osc_pin_clkout && clk_cfg.osc_pin_gpio);
  endproperty
  property p_wdt;
    wdt_cfg.wdt_run |-> wdt_cfg.low_power_internal_rc_on;
  endproperty
  property p_pre;
    wdt_cfg.pre_ratio_log2 == 8'h05 || wdt_cfg.pre_ratio_log2 == 8'h07;
  endproperty
  property p_pd;
    power_down |=> !code_run [*8];
  endproperty
  property p_lock;
    sys_clk_hold |-> !code_run;
  endproperty
  property p_rise;
    $rose(code_run) |-> !sys_clk_hold && !power_down;
  endproperty
  property p_err;
    psel && penable && paddr > 12'h01C |-> pready && pslverr;
  endproperty

  a_hold: assert property (p_hold) else $error("config moved without reset");
  a_fsm: assert property (p_fsm) else $error("monitor on with switching off");
  a_pin: assert property (p_pin) else $error("pin both clock and gpio");
  a_wdt: assert property (p_wdt) else $error("watchdog runs without clock");
  a_pre: assert property (p_pre) else $error("bad prescale ratio");
  a_pd: assert property (p_pd) else $error("run too soon after power down");
  a_lock: assert property (p_lock) else $error("run while clock held");
  a_rise: assert property (p_rise) else $error("run rose while held");
  a_err: assert property (p_err) else $error("unmapped access not flagged");

  c_run: cover property ($rose(code_run));
  c_hold: cover property (sys_clk_hold);
  c_err: cover property (psel && penable && pslverr);
endmodule

bind cfd_decode cfd_decode_asserts i_cfd_decode_asserts (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .brownout_reset, .power_down, .clk_cfg, .wdt_cfg, .pwm_cfg,
  .code_run, .sys_clk_hold);

// *** tb/cfd_decode_tb_top.sv ***
// Self-checking bench for the configuration decoder
module cfd_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cfd_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, er, brownout_reset = 0, power_down = 0;
  logic        pll_locked = 1, selected_osc_ready = 1, code_run, sys_clk_hold, on_selected_src;
  logic [7:0]  nv_general_segment = 0, nv_osc_select = 0, nv_osc_config = 0;
  logic [7:0]  nv_watchdog = 0, nv_power_on = 0, nv_debug = 0;
  cfd_clk_s    clk_cfg;
  cfd_wdt_s    wdt_cfg;
  cfd_pwm_s    pwm_cfg;
  int          mismatches = 0, total_checks = 0, cyc = 0, n;

  // Short counts keep every power-up sequence to a few hundred cycles
  cfd_decode #(.STARTUP_CYCLES(10), .PWRUP_UNIT_CYC(4)) i_cfd_decode (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .nv_general_segment,
    .nv_osc_select, .nv_osc_config, .nv_watchdog, .nv_power_on, .nv_debug, .brownout_reset,
    .power_down, .pll_locked, .selected_osc_ready, .clk_cfg, .wdt_cfg, .pwm_cfg, .code_run,
    .sys_clk_hold, .on_selected_src);

  always #2 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wait_run();
    n = 0;
    while (code_run !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  // One vector per code over k = 0..7 reaches every field value except the PLL lock-wait bit (always 1) and postscaler codes below 8
  function automatic logic [47:0] vec(input logic [2:0] k);
    return {7'h00, k[0], k[0], 4'h0, k, k[1:0], 3'h0, k[2], k[1:0], k[1], k[0], 1'b1,
      k[2], 1'b1, k, 1'b0, k[0], k[1], ~k[0], 1'b0, k, 6'h00, k[1:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // A nonzero lk withholds PLL lock for lk cycles after the brown-out
  task automatic t_cfg(input logic [47:0] w, input int lk = 0);
    logic [7:0] g, s, c, d, p, i;
    int         ex;
    cfd_clk_s   ec;
    {g, s, c, d, p, i} = w;
    {nv_general_segment, nv_osc_select, nv_osc_config, nv_watchdog, nv_power_on, nv_debug} <= w;
    brownout_reset <= 1;
    if (lk > 0)
      pll_locked <= 0;
    @(posedge pclk);
    brownout_reset <= 0;
    // Run still shows high until the restart edge has passed
    @(posedge pclk);
    ex = 10 + (p[2:0] != 0 ? 4 << (p[2:0] - 1) : 0);
    if (lk > 0)
    begin
      repeat (lk) @(posedge pclk);
      chk("pll hold", 2'b10, {sys_clk_hold, code_run});
      pll_locked <= 1;
      ex = 2;
    end
    wait_run();
    chk("startup delay", 1, n >= ex && n <= ex + 4);
    ec = '{g[0], cfd_osc_e'(s[2:0]), s[7], !c[7], c[7:6] == 0, cfd_pmode_e'(c[1:0]), c[2],
      !c[2], d[5]};
    // Crystal modes own the pin: neither clock out nor GPIO
    if (^c[1:0])
    begin
      ec.osc_pin_clkout = 1'b0;
      ec.osc_pin_gpio = 1'b0;
    end
    chk("clk_cfg", ec, clk_cfg);
    chk("selected src", 1, on_selected_src);
    chk("wdt_cfg", {d[7], d[7], !d[6], d[4] ? 8'h07 : 8'h05, 1'b0, d[3:0]}, wdt_cfg);
    chk("pwm_cfg", {p[6], p[4], p[5], ~i[1:0], i[1:0] == 0}, pwm_cfg);
    apb(0, ADDR_POR, 0);
    chk("por word", {24'h0000_00, p}, rd);
    $display("t_cfg %h done", w);
  endtask

  task automatic t_regs();
    apb(1, ADDR_GS, 0);
    apb(0, ADDR_GS, 0);
    chk("ro word", 32'h0000_0001, rd);
    apb(0, 12'h040, 0);
    chk("unmapped err", 1, er);
    apb(1, ADDR_CTRL, 0);
    chk("fixed wdt", 1, wdt_cfg.wdt_run);
    t_cfg(vec(3'h5));
    apb(1, ADDR_CTRL, 32'h0000_0001);
    @(posedge pclk);
    chk("soft wdt on", 2'b11, {wdt_cfg.wdt_run, wdt_cfg.low_power_internal_rc_on});
    apb(1, ADDR_CTRL, 0);
    @(posedge pclk);
    chk("soft wdt off", 0, wdt_cfg.wdt_run);
    $display("t_regs done");
  endtask

  task automatic t_lock();
    t_cfg(vec(3'h3), 60);
    t_cfg(48'h0001_0000_0000 | vec(3'h0), 60);
    $display("t_lock done");
  endtask

  task automatic t_pd();
    @(posedge pclk);
    power_down <= 1;
    @(posedge pclk);
    power_down <= 0;
    @(posedge pclk);
    wait_run();
    chk("hold after power down", 1, n >= 9 && n < 2000);
    apb(1, ADDR_CTRL, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk("wake restarts", 0, code_run);
    wait_run();
    chk("hold after wake", 1, n >= 9 && n < 2000);
    $display("t_pd done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge pclk);
    chk("run in reset", 0, code_run);
    presetn <= 1;
    wait_run();
    chk("power-on hold", 1, n >= 10 && n < 2000);
    for (int k = 0; k < 8; k++)
      t_cfg(vec(k[2:0]));
    t_regs();
    t_pd();
    t_lock();
    results();
  end
endmodule
